/* design/eds_regs.vh */
// Constants for the ECC DRAM bus sequencer.
`ifndef EDS_REGS_VH
`define EDS_REGS_VH
`define EDS_CLK_NS         5
`define EDS_SEQ_PERIOD_NS  100
`define EDS_SEQ_CYC        (`EDS_SEQ_PERIOD_NS / `EDS_CLK_NS)
`define EDS_LAG_NS         60
`define EDS_LAG_CYC        (`EDS_LAG_NS / `EDS_CLK_NS)
`define EDS_REF_PERIOD_NS  12500
`define EDS_REF_CYC        (`EDS_REF_PERIOD_NS / `EDS_CLK_NS)
`define EDS_ARB_NS         60
`define EDS_ARB_CYC        ((`EDS_ARB_NS + `EDS_CLK_NS - 1) / `EDS_CLK_NS)
`define EDS_TCNT_W         5
`define EDS_RCNT_W         12
`define EDS_LOC_W          16
`define EDS_BANK_W         4
`define EDS_NBANK          8
`define EDS_CHK_W          6
`define EDS_CMD_W          3
`define EDS_CMD_RD         3'h1
`define EDS_CMD_WR         3'h2
`define EDS_CHK_MODE_BIT   2
`endif

/* design/eds_timer.v */
// Two-phase sequencing timer: primary and lagged 100 ns enables.
`default_nettype none
`include "eds_regs.vh"
module eds_timer (
  input  wire clock,            // System clock
  input  wire sys_rst,          // Async reset, active high
  output reg  seq_clk_primary,  // Primary phase pulse
  output reg  seq_clk_lagged    // Lagged phase pulse
);
  reg [`EDS_TCNT_W-1:0] cnt_q;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q           <= {`EDS_TCNT_W{1'b0}};
      seq_clk_primary <= 1'b0;
      seq_clk_lagged  <= 1'b0;
    end else begin
      if (cnt_q == `EDS_SEQ_CYC - 1)
        cnt_q <= {`EDS_TCNT_W{1'b0}};
      else
        cnt_q <= cnt_q + 5'h01;
      seq_clk_primary <= (cnt_q == `EDS_SEQ_CYC - 1);
      seq_clk_lagged  <= (cnt_q == `EDS_LAG_CYC - 1);
    end
  end
endmodule // eds_timer
`default_nettype wire

/* design/eds_refresh.v */
// Refresh timebase, request latch and refresh address counter.
`default_nettype none
`include "eds_regs.vh"
module eds_refresh (
  input  wire                   clock,                  // System clock
  input  wire                   sys_rst,                // Async reset
  input  wire                   power_normal,           // Power good level
  input  wire                   refresh_request_clear,  // End of refresh pulse
  input  wire                   refresh_count_clk,      // Counter advance pulse
  output reg                    refresh_timebase,       // Oscillator tick
  output reg                    refresh_req,            // Latched request
  output reg  [`EDS_LOC_W-1:0]  refresh_addr            // Refresh address
);
  reg [`EDS_RCNT_W-1:0] osc_q;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      osc_q            <= {`EDS_RCNT_W{1'b0}};
      refresh_timebase <= 1'b0;
      refresh_req      <= 1'b0;
      refresh_addr     <= {`EDS_LOC_W{1'b0}};
    end else begin
      if (osc_q == `EDS_REF_CYC - 1)
        osc_q <= {`EDS_RCNT_W{1'b0}};
      else
        osc_q <= osc_q + 12'h001;
      refresh_timebase <= (osc_q == `EDS_REF_CYC - 1);
      // latch only when power normal; set beats clear
      if (refresh_timebase && power_normal)
        refresh_req <= 1'b1;
      else if (refresh_request_clear)
        refresh_req <= 1'b0;
      if (refresh_count_clk)
        refresh_addr <= refresh_addr + 16'h0001;
    end
  end
endmodule // eds_refresh
`default_nettype wire

/* design/eds_sequencer.v */
// Microsequenced ECC DRAM controller: arbitration, array timing, ECC and bus sync.
`default_nettype none
`include "eds_regs.vh"
module eds_sequencer (
  input  wire                   clock,                  // 200 MHz clock
  input  wire                   sys_rst,                // Async reset, active high
  input  wire                   master_sync,            // Bus master sync level
  input  wire                   bus_write,              // 1 = write cycle
  input  wire                   reg_select,             // Access targets register
  input  wire [1:0]             bus_byte_sel,           // Byte lanes of a write
  input  wire [`EDS_LOC_W-1:0]  bus_loc,                // Location within bank
  input  wire [`EDS_BANK_W-1:0] bus_bank,               // Bank number
  input  wire                   ecc_error,              // Error from correct unit
  input  wire                   ecc_uncorrectable,      // Error cannot be fixed
  input  wire                   correct_disable,        // Correction off
  input  wire                   check_mode,             // Diagnostic check mode
  input  wire [`EDS_CHK_W-1:0]  ecc_checkbits,          // Check bits from array
  input  wire                   power_normal,           // Power good
  output wire                   seq_clk_primary,        // Primary phase pulse
  output wire                   seq_clk_lagged,         // Lagged phase pulse
  output reg                    seq_busy,               // Sequencer running
  output reg                    next_addr_select,       // Microaddress MSB
  output reg  [`EDS_LOC_W-1:0]  array_addr,             // Array address
  output reg  [`EDS_NBANK-1:0]  row_strobe_sel,         // Per-bank row strobe
  output reg                    row_strobe_timing,      // Row strobe timing
  output reg                    row_col_switch_timing,  // Row to column switch
  output reg                    col_strobe_timing,      // Column strobe timing
  output reg                    write_strobe_timing,    // Write enable timing
  output reg                    branch_on_fault,        // Error branch select
  output reg                    ecc_input_latch_load,   // Load read latches
  output reg                    ecc_output_latch_enable, // Output latch enable
  output reg  [1:0]             ecc_out_byte_sel,       // Output byte enables
  output reg  [1:0]             byte_load_enable,       // Write byte loads
  output reg                    ecc_generate,           // Data stable, generate
  output reg                    checkbit_drive_enable,  // Drive check bits
  output reg                    ecc_bypass,             // Pass-through
  output reg                    ack_launch,             // Normal ack start
  output reg                    ack_direct_set,         // Ack after correction
  output reg                    slave_sync,             // Ack to bus master
  output reg                    reg_cmd_decode_strobe,  // Delayed decode strobe
  output reg  [`EDS_CMD_W-1:0]  reg_cmd_code,           // Register command
  output reg                    refresh_cycle_active,   // Refresh in progress
  output reg                    refresh_request_clear,  // Refresh end pulse
  output wire                   refresh_timebase,       // Refresh oscillator
  output reg  [`EDS_CHK_W-1:0]  diag_checkbits          // Check bits for register
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0, ST_ROW = 4'h1, ST_MUX = 4'h2, ST_COL = 4'h3,
                   ST_DATA = 4'h4, ST_FIX = 4'h5, ST_ACK = 4'h6, ST_REG = 4'h7,
                   ST_REGD = 4'h8, ST_WAIT = 4'h9, ST_RFEND = 4'ha;

  reg [3:0]             st_q;
  reg                   pend_q, sel_q, wr_q, reg_q, err_q;
  reg [`EDS_LOC_W-1:0]  loc_q;
  reg [`EDS_BANK_W-1:0] bank_q;
  reg [1:0]             bsel_q;
  reg [3:0]             arb_q;
  reg                   refresh_count_clk;
  wire                  refresh_req;
  wire [`EDS_LOC_W-1:0] refresh_addr;
  wire                  tick = seq_clk_primary;

  eds_timer u_timer (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .seq_clk_primary (seq_clk_primary),
    .seq_clk_lagged  (seq_clk_lagged)
  );

  eds_refresh u_refresh (
    .clock                 (clock),
    .sys_rst               (sys_rst),
    .power_normal          (power_normal),
    .refresh_request_clear (refresh_request_clear),
    .refresh_count_clk     (refresh_count_clk),
    .refresh_timebase      (refresh_timebase),
    .refresh_req           (refresh_req),
    .refresh_addr          (refresh_addr)
  );

  // ---------------------------------------------------------------
  // Array address and bank decode
  // ---------------------------------------------------------------
  // select access or refresh address
  always @* begin
    if (refresh_cycle_active)
      array_addr = refresh_addr;
    else
      array_addr = loc_q;
  end

  // Refresh strobes every bank so the whole row is restored at once.
  genvar gb;
  generate
    for (gb = 0; gb < `EDS_NBANK; gb = gb + 1) begin : g_bank
      always @* begin
        row_strobe_sel[gb] = row_strobe_timing &
                             (refresh_cycle_active | (bank_q == gb));
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q                    <= ST_IDLE;
      pend_q                  <= 1'b0;
      sel_q                   <= 1'b0;
      arb_q                   <= 4'h0;
      wr_q                    <= 1'b0;
      reg_q                   <= 1'b0;
      err_q                   <= 1'b0;
      loc_q                   <= {`EDS_LOC_W{1'b0}};
      bank_q                  <= {`EDS_BANK_W{1'b0}};
      bsel_q                  <= 2'h0;
      seq_busy                <= 1'b0;
      next_addr_select        <= 1'b0;
      row_strobe_timing       <= 1'b0;
      row_col_switch_timing   <= 1'b0;
      col_strobe_timing       <= 1'b0;
      write_strobe_timing     <= 1'b0;
      branch_on_fault         <= 1'b0;
      ecc_input_latch_load    <= 1'b0;
      ecc_output_latch_enable <= 1'b0;
      ecc_out_byte_sel        <= 2'h0;
      byte_load_enable        <= 2'h0;
      ecc_generate            <= 1'b0;
      checkbit_drive_enable   <= 1'b0;
      ecc_bypass              <= 1'b0;
      ack_launch              <= 1'b0;
      ack_direct_set          <= 1'b0;
      slave_sync              <= 1'b0;
      reg_cmd_decode_strobe   <= 1'b0;
      reg_cmd_code            <= 3'h0;
      refresh_cycle_active    <= 1'b0;
      refresh_request_clear   <= 1'b0;
      refresh_count_clk       <= 1'b0;
      diag_checkbits          <= {`EDS_CHK_W{1'b0}};
    end else begin
      refresh_request_clear <= 1'b0;
      refresh_count_clk     <= 1'b0;
      ack_launch            <= 1'b0;
      ack_direct_set        <= 1'b0;
      if (st_q == ST_IDLE && !pend_q && (master_sync || refresh_req)) begin
        pend_q <= 1'b1;
        sel_q  <= refresh_req;
        arb_q  <= 4'h0;
      end else if (pend_q && arb_q != `EDS_ARB_CYC)
        arb_q <= arb_q + 4'h1;
      // Slave sync stays up until the master drops its sync.
      if (!master_sync)
        slave_sync <= 1'b0;
      if (tick) begin
        case (st_q)
          ST_IDLE: begin
            if (pend_q && arb_q == `EDS_ARB_CYC) begin
              pend_q   <= 1'b0;
              seq_busy <= 1'b1;
              if (sel_q) begin
                refresh_cycle_active <= 1'b1;
                row_strobe_timing    <= 1'b1;
                st_q                 <= ST_ROW;
              end else if (master_sync) begin
                wr_q   <= bus_write;
                reg_q  <= reg_select;
                loc_q  <= bus_loc;
                bank_q <= bus_bank;
                bsel_q <= bus_byte_sel;
                if (reg_select) begin
                  reg_cmd_code <= bus_write ? `EDS_CMD_WR : `EDS_CMD_RD;
                  st_q         <= ST_REG;
                end else begin
                  row_strobe_timing <= 1'b1;
                  st_q              <= ST_ROW;
                end
              end else
                seq_busy <= 1'b0;
            end
          end
          ST_ROW: begin
            row_col_switch_timing <= 1'b1;
            st_q                  <= refresh_cycle_active ? ST_RFEND : ST_MUX;
            if (wr_q && !refresh_cycle_active) begin
              byte_load_enable <= bsel_q;
            end
          end
          ST_MUX: begin
            col_strobe_timing <= 1'b1;
            if (wr_q) begin
              ecc_generate <= 1'b1;
              st_q         <= ST_COL;
            end else begin
              ecc_input_latch_load <= 1'b1;
              st_q                 <= ST_DATA;
            end
          end
          ST_COL: begin
            checkbit_drive_enable <= 1'b1;
            write_strobe_timing   <= 1'b1;
            ack_launch <= 1'b1;
            slave_sync <= 1'b1;
            st_q       <= ST_WAIT;
          end
          ST_DATA: begin
            ecc_input_latch_load <= 1'b0;
            // keep check bits for diagnostic read
            if (check_mode)
              diag_checkbits <= ecc_checkbits;
            ecc_bypass <= correct_disable | ecc_uncorrectable;
            ecc_output_latch_enable <= 1'b1;
            ecc_out_byte_sel        <= 2'h3;
            branch_on_fault  <= 1'b1;
            next_addr_select <= ecc_error & ~correct_disable & ~ecc_uncorrectable;
            err_q            <= ecc_error & ~correct_disable & ~ecc_uncorrectable;
            st_q             <= ST_FIX;
          end
          ST_FIX: begin
            branch_on_fault <= 1'b0;
            if (err_q) begin
              ack_direct_set <= 1'b1;
              err_q          <= 1'b0;
              st_q           <= ST_ACK;
            end else begin
              ack_launch <= 1'b1;
              slave_sync <= 1'b1;
              st_q       <= ST_WAIT;
            end
          end
          ST_ACK: begin
            slave_sync <= 1'b1;
            st_q       <= ST_WAIT;
          end
          ST_REG: begin
            // The strobe trails the code by one sequencer period so the register sees stable inputs.
            reg_cmd_decode_strobe <= 1'b1;
            ecc_bypass <= 1'b1;
            if (wr_q)
              diag_checkbits <= {`EDS_CHK_W{1'b0}};
            st_q <= ST_REGD;
          end
          ST_REGD: begin
            reg_cmd_decode_strobe <= 1'b0;
            slave_sync            <= 1'b1;
            ack_launch            <= 1'b1;
            st_q                  <= ST_WAIT;
          end
          ST_RFEND: begin
            refresh_request_clear <= 1'b1;
            refresh_cycle_active  <= 1'b0;
            // The row strobe ends with the cycle, so a stale bank is never strobed.
            row_strobe_timing     <= 1'b0;
            row_col_switch_timing <= 1'b0;
            refresh_count_clk     <= 1'b1;
            st_q                  <= ST_WAIT;
          end
          ST_WAIT: begin
            row_strobe_timing       <= 1'b0;
            row_col_switch_timing   <= 1'b0;
            col_strobe_timing       <= 1'b0;
            write_strobe_timing     <= 1'b0;
            byte_load_enable        <= 2'h0;
            ecc_generate            <= 1'b0;
            checkbit_drive_enable   <= 1'b0;
            ecc_output_latch_enable <= 1'b0;
            ecc_out_byte_sel        <= 2'h0;
            next_addr_select        <= 1'b0;
            ecc_bypass              <= 1'b0;
            reg_cmd_code            <= 3'h0;
            // Waiting for the master to drop sync stops a held cycle being served twice.
            if (!master_sync || !slave_sync) begin
              seq_busy <= 1'b0;
              st_q     <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // eds_sequencer
`default_nettype wire

/* sim/eds_bus_master.sv */
// Behavioural bus master that requests read, write and register cycles.
`default_nettype none
module eds_bus_master (
  input  wire logic        clock,         // System clock
  input  wire logic        slave_sync,    // Acknowledge from memory
  output var  logic        master_sync,   // Cycle request
  output var  logic        bus_write,     // Write cycle
  output var  logic        reg_select,    // Register target
  output var  logic [1:0]  bus_byte_sel,  // Byte lanes
  output var  logic [15:0] bus_loc,       // Location in bank
  output var  logic [3:0]  bus_bank       // Bank number
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {master_sync, bus_write, reg_select, bus_byte_sel, bus_loc, bus_bank} = 25'h0;
  end
  task automatic cycle(input logic wr, input logic rs, input logic [1:0] bs, input logic [15:0] loc,
                       input logic [3:0] bk, input int slow, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge clock);
    {bus_write, reg_select, bus_byte_sel, bus_loc, bus_bank} = {wr, rs, bs, loc, bk};
    master_sync = 1'b1;
    while (n < 400 && !ok) begin
      @(posedge clock);
      ok = slave_sync;
      n++;
    end
    repeat (slow) @(posedge clock);
    @(negedge clock);
    // Released byte, location and bank lines show garbage, so a late sampler cannot pass by luck.
    master_sync = 1'b0;
    {bus_byte_sel, bus_loc, bus_bank} = ~{bus_byte_sel, bus_loc, bus_bank};
    n = 0;
    while (n < 400 && slave_sync) begin
      @(posedge clock);
      n++;
    end
    ok = ok && !slave_sync;
    // Return on a falling edge so the caller's next stimulus stays off the sampling edge.
    @(negedge clock);
  endtask
endmodule // eds_bus_master
`default_nettype wire

/* sim/eds_seq_asserts.sv */
// Port-level assertions for the ECC DRAM bus sequencer.
`default_nettype none
module eds_seq_asserts (
  input wire logic        clock,                  // System clock
  input wire logic        sys_rst,                // Async reset
  input wire logic        master_sync,            // Bus request
  input wire logic        reg_select,             // Register access
  input wire logic [1:0]  bus_byte_sel,           // Write lanes
  input wire logic [15:0] bus_loc,                // Location
  input wire logic [3:0]  bus_bank,               // Bank
  input wire logic        seq_clk_primary,        // Primary phase
  input wire logic        seq_clk_lagged,         // Lagged phase
  input wire logic [15:0] array_addr,             // Array address
  input wire logic [7:0]  row_strobe_sel,         // Bank strobes
  input wire logic        row_strobe_timing,      // Row timing
  input wire logic        row_col_switch_timing,  // Switch timing
  input wire logic        col_strobe_timing,      // Column timing
  input wire logic        ecc_input_latch_load,   // Read latch load
  input wire logic [1:0]  byte_load_enable,       // Write loads
  input wire logic        ecc_generate,           // Generate
  input wire logic        checkbit_drive_enable,  // Drive check bits
  input wire logic        ack_direct_set,         // Late ack
  input wire logic        slave_sync,             // Ack
  input wire logic        refresh_cycle_active,   // Refresh running
  input wire logic        refresh_request_clear,  // Refresh end
  input wire logic        refresh_timebase        // Oscillator tick
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] ref_gap_q;
  logic        ref_seen_q;
  // Gap counter saturates so a dead oscillator still trips the bound.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ref_gap_q  <= 12'h0;
      ref_seen_q <= 1'b0;
    end else if (refresh_timebase) begin
      ref_gap_q  <= 12'h1;
      ref_seen_q <= 1'b1;
    end else if (ref_gap_q != 12'hfff) begin
      ref_gap_q <= ref_gap_q + 12'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_PRI_PERIOD: assert property (seq_clk_primary |-> ##20 seq_clk_primary)
    else $error("primary phase period wrong");
  AST_LAG_PHASE: assert property (seq_clk_primary |-> ##12 seq_clk_lagged)
    else $error("lagged phase offset wrong");
  AST_REF_PERIOD: assert property (ref_seen_q |-> ref_gap_q <= 12'h9c4 &&
    (!refresh_timebase || ref_gap_q == 12'h9c4))
    else $error("refresh oscillator period wrong");
  AST_BANK_ONEHOT: assert property (row_strobe_timing && master_sync && !slave_sync && !reg_select
    && !refresh_cycle_active |-> row_strobe_sel == (8'h01 << bus_bank[2:0]) && array_addr == bus_loc)
    else $error("bank strobe or array address wrong");
  AST_ROW_COL: assert property ($rose(row_col_switch_timing) |-> row_strobe_timing && !col_strobe_timing)
    else $error("row to column switch out of order");
  AST_REF_CLEAR: assert property (refresh_request_clear |=> !refresh_cycle_active)
    else $error("refresh cycle not cleared");
  AST_ACK_CAUSE: assert property ($rose(slave_sync) |-> master_sync)
    else $error("acknowledge without request");
  AST_ACK_DROP: assert property ($fell(master_sync) |-> ##[0:4] !slave_sync)
    else $error("acknowledge held after request drop");
  AST_LATE_ACK: assert property (ack_direct_set |-> ##[0:21] slave_sync)
    else $error("direct set gave no acknowledge");
  AST_GEN_FIRST: assert property ($rose(checkbit_drive_enable) |-> $past(ecc_generate))
    else $error("check bits driven before generate");
  AST_BYTE_LOAD: assert property (ecc_generate && master_sync |-> byte_load_enable == bus_byte_sel)
    else $error("write byte loads wrong");
  AST_ONE_OWNER: assert property (ecc_input_latch_load |-> !refresh_cycle_active)
    else $error("read latch load during refresh");
endmodule // eds_seq_asserts
`default_nettype wire

/* sim/testbench.sv */
// Self-checking testbench for the ECC DRAM bus sequencer.
`default_nettype none
bind eds_sequencer eds_seq_asserts u_chk (.clock, .sys_rst, .master_sync, .reg_select, .bus_byte_sel, .bus_loc,
  .bus_bank, .seq_clk_primary, .seq_clk_lagged, .array_addr, .row_strobe_sel, .row_strobe_timing,
  .row_col_switch_timing, .col_strobe_timing, .ecc_input_latch_load, .byte_load_enable, .ecc_generate,
  .checkbit_drive_enable, .ack_direct_set, .slave_sync, .refresh_cycle_active, .refresh_request_clear,
  .refresh_timebase);
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, sys_rst, master_sync, bus_write, reg_select, ecc_error, ecc_uncorrectable;
  logic correct_disable, check_mode, power_normal, seq_clk_primary, seq_clk_lagged, seq_busy;
  logic next_addr_select, row_strobe_timing, row_col_switch_timing, col_strobe_timing, write_strobe_timing;
  logic branch_on_fault, ecc_input_latch_load, ecc_output_latch_enable, ecc_generate, checkbit_drive_enable;
  logic ecc_bypass, ack_launch, ack_direct_set, slave_sync, reg_cmd_decode_strobe, refresh_cycle_active;
  logic refresh_request_clear, refresh_timebase;
  logic [1:0]  bus_byte_sel, ecc_out_byte_sel, byte_load_enable, obs_q, ble_q;
  logic [15:0] bus_loc, array_addr;
  logic [3:0]  bus_bank;
  logic [5:0]  ecc_checkbits, diag_checkbits;
  logic [7:0]  row_strobe_sel;
  logic [2:0]  reg_cmd_code, cmd_q;
  logic f_dset, f_byp, f_na, f_lin, f_gen, f_drv, f_clr, f_ref, f_we, f_br, f_al;
  int bad_count, n_tests, cyc;
  eds_sequencer u_dut (.clock, .sys_rst, .master_sync, .bus_write, .reg_select, .bus_byte_sel, .bus_loc,
    .bus_bank, .ecc_error, .ecc_uncorrectable, .correct_disable, .check_mode, .ecc_checkbits, .power_normal,
    .seq_clk_primary, .seq_clk_lagged, .seq_busy, .next_addr_select, .array_addr, .row_strobe_sel,
    .row_strobe_timing, .row_col_switch_timing, .col_strobe_timing, .write_strobe_timing, .branch_on_fault,
    .ecc_input_latch_load, .ecc_output_latch_enable, .ecc_out_byte_sel, .byte_load_enable, .ecc_generate,
    .checkbit_drive_enable, .ecc_bypass, .ack_launch, .ack_direct_set, .slave_sync, .reg_cmd_decode_strobe,
    .reg_cmd_code, .refresh_cycle_active, .refresh_request_clear, .refresh_timebase, .diag_checkbits);
  eds_bus_master u_master (.clock, .slave_sync, .master_sync, .bus_write, .reg_select, .bus_byte_sel,
    .bus_loc, .bus_bank);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Sticky observations of one cycle; cleared by each scenario.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (ack_direct_set) f_dset <= 1'b1;
    if (ecc_bypass) f_byp <= 1'b1;
    if (next_addr_select) f_na <= 1'b1;
    if (ecc_input_latch_load) f_lin <= 1'b1;
    if (ecc_generate) f_gen <= 1'b1;
    if (checkbit_drive_enable) f_drv <= 1'b1;
    if (refresh_request_clear) f_clr <= 1'b1;
    if (refresh_cycle_active) f_ref <= 1'b1;
    if (write_strobe_timing) f_we <= 1'b1;
    if (branch_on_fault) f_br <= 1'b1;
    if (ack_launch) f_al <= 1'b1;
    if (ecc_output_latch_enable) obs_q <= ecc_out_byte_sel;
    if (ecc_generate) ble_q <= byte_load_enable;
    if (reg_cmd_decode_strobe) cmd_q <= reg_cmd_code;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clr;
    {f_dset, f_byp, f_na, f_lin, f_gen, f_drv, f_clr, f_ref, f_we, f_br, f_al, obs_q, ble_q, cmd_q} = 18'h0;
  endtask
  task automatic run(input logic wr, input logic rs, input logic [1:0] bs, input logic [3:0] bk, input int slow);
    logic ok;
    int n;
    n = 0;
    while (seq_busy !== 1'b0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    clr();
    u_master.cycle(wr, rs, bs, {bk, 12'h5a3}, bk, slow, ok);
    check(ok, 1'b1);
  endtask
  task automatic t_timer;
    int a, b, c;
    @(posedge seq_clk_primary);
    @(negedge clock) a = cyc;
    @(posedge seq_clk_lagged);
    @(negedge clock) b = cyc;
    @(posedge seq_clk_primary);
    @(negedge clock) c = cyc;
    check(16'(b - a), 16'd12);
    check(16'(c - a), 16'd20);
    $display("t_timer done");
  endtask
  task automatic t_write;
    for (int k = 0; k < 8; k++) begin
      run(1'b1, 1'b0, 2'(k % 3 + 1), 4'(k), (k % 2) * 30);
      check(ble_q, 16'(k % 3 + 1));
      check({f_gen, f_drv, f_we, f_al}, 16'hf);
    end
    $display("t_write done");
  endtask
  task automatic t_read;
    {ecc_error, correct_disable, check_mode} = 3'b100;
    run(1'b0, 1'b0, 2'h0, 4'h2, 0);
    check({f_dset, f_na, f_lin, f_br, f_al}, 16'h1e);
    check(obs_q, 16'h3);
    {ecc_uncorrectable, correct_disable} = 2'b10;
    run(1'b0, 1'b0, 2'h0, 4'h5, 0);
    check({f_byp, f_dset, f_br, f_al}, 16'hb);
    {ecc_uncorrectable, correct_disable} = 2'b01;
    run(1'b0, 1'b0, 2'h0, 4'h6, 5);
    check({f_byp, f_dset}, 16'h2);
    {ecc_error, correct_disable, check_mode, ecc_checkbits} = 9'h02d | 9'h040;
    run(1'b0, 1'b0, 2'h0, 4'h7, 0);
    check(diag_checkbits, 16'h2d);
    run(1'b1, 1'b1, 2'h3, 4'h0, 0);
    check(cmd_q, 16'h2);
    check(diag_checkbits, 16'h0);
    run(1'b0, 1'b1, 2'h0, 4'h0, 0);
    check({cmd_q, f_byp}, 16'h3);
    check_mode = 1'b0;
    $display("t_read done");
  endtask
  task automatic t_refresh;
    int n;
    @(posedge refresh_timebase);
    @(negedge clock);
    run(1'b1, 1'b0, 2'h3, 4'h4, 0);
    n = 0;
    while (!f_clr && n < 2700) begin
      @(negedge clock);
      n++;
    end
    check({f_ref, f_clr}, 16'h3);
    repeat (20) @(negedge clock);
    check({refresh_cycle_active, seq_busy}, 16'h0);
    power_normal = 1'b0;
    clr();
    repeat (5100) @(negedge clock);
    check(f_ref, 1'b0);
    power_normal = 1'b1;
    $display("t_refresh done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {sys_rst, ecc_error, ecc_uncorrectable, correct_disable, check_mode, power_normal} = 6'h21;
    {ecc_checkbits, bad_count, n_tests, cyc} = '0;
    clr();
    repeat (8) @(posedge clock);
    @(negedge clock) sys_rst = 1'b0;
    t_timer();
    t_write();
    t_read();
    t_refresh();
    tally_and_finish();
  end
  // Watchdog: the scenarios need about 8000 clocks.
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
